// File: rtl/rra_pkg.sv
// Package: constants, selections and carrier types for the relay range alarm block
package rra_pkg;

  localparam int unsigned CLK_HZ        = 20000000;
  localparam int unsigned SEC_CYCLES    = CLK_HZ;
  localparam int unsigned VAL_W         = 16;
  localparam int unsigned DLY_W         = 8;
  localparam int unsigned NUM_CHAN      = 6;
  localparam int unsigned NUM_RELAY     = 2;
  localparam int unsigned FUNC_W        = 3;
  localparam logic [2:0]  FUNC_RESET    = 3'h0;

  // Remote channel function selections, in keypad stepping order
  typedef enum logic [2:0] {
    RRA_FN_DISABLED,
    RRA_FN_CLR_R1,
    RRA_FN_CLR_R2,
    RRA_FN_CLR_ALL,
    RRA_FN_TOTAL,
    RRA_FN_R1_TOTAL,
    RRA_FN_R2_TOTAL,
    RRA_FN_GLOBAL
  } rra_func_t;

  // Relay operating mode
  typedef enum logic [1:0] {
    RRA_MODE_OFF,
    RRA_MODE_RANGE,
    RRA_MODE_MANUAL
  } rra_mode_t;

  // Per-relay configuration
  typedef struct packed {
    rra_mode_t          mode;
    logic [VAL_W-1:0]   upper_trip;
    logic [VAL_W-1:0]   lower_trip;
    logic [VAL_W-1:0]   upper_band_width;
    logic [VAL_W-1:0]   lower_band_width;
    logic [DLY_W-1:0]   assert_delay;
    logic [DLY_W-1:0]   release_delay;
    logic               hold_until_cleared;
    logic               forced_on;
  } rra_relay_cfg_t;

  // Actions decoded from one channel selection
  typedef struct packed {
    logic clr_r1;
    logic clr_r2;
    logic clr_total;
  } rra_action_t;

  function automatic rra_action_t rra_decode(input rra_func_t f);
    rra_action_t a;
    a = '0;
    case (f)
      RRA_FN_CLR_R1:   a.clr_r1 = 1'b1;
      RRA_FN_CLR_R2:   a.clr_r2 = 1'b1;
      RRA_FN_CLR_ALL:  a = '{clr_r1: 1'b1, clr_r2: 1'b1, clr_total: 1'b0};
      RRA_FN_TOTAL:    a.clr_total = 1'b1;
      RRA_FN_R1_TOTAL: a = '{clr_r1: 1'b1, clr_r2: 1'b0, clr_total: 1'b1};
      RRA_FN_R2_TOTAL: a = '{clr_r1: 1'b0, clr_r2: 1'b1, clr_total: 1'b1};
      RRA_FN_GLOBAL:   a = '1;
      default:         a = '0;
    endcase
    return a;
  endfunction

endpackage

// File: rtl/rra_sec_tick.sv
// One-second enable pulse divider
`timescale 1ns/1ns
module rra_sec_tick
  import rra_pkg::*;
#(
  parameter int unsigned DIV = SEC_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_b,
  output logic      tick
);

  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic        next_tick;

  always_comb begin
    next_tick = 1'b0;
    next_cnt  = cnt + 32'h1;
    if (cnt >= DIV - 1) begin
      next_cnt  = 32'h0;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt  <= 32'h0;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end

endmodule // rra_sec_tick

// File: rtl/rra_relay.sv
// One relay channel: range alarm with hysteresis, delays, latch and manual force
`timescale 1ns/1ns
module rra_relay
  import rra_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             sec_tick,
  input  wire logic [VAL_W-1:0] value,
  input  rra_relay_cfg_t        cfg,
  input  wire logic             clear,
  output logic                  energized,
  output logic                  indicator
);

  typedef enum logic [1:0] {ST_IDLE, ST_ARMING, ST_ON, ST_RELEASING} rra_rst_t;

  rra_rst_t         st;
  rra_rst_t         next_st;
  logic [DLY_W-1:0] secs;
  logic [DLY_W-1:0] next_secs;
  logic             latched;
  logic             next_latched;
  logic             next_energized;
  logic             next_indicator;
  logic             trip;
  logic             hold;
  logic [VAL_W:0]   upper_edge;
  logic [VAL_W:0]   lower_edge;

  always_comb begin
    // Widened edges; a band wider than the upper trip borrows into the top bit and then reaches down to zero
    upper_edge = {1'b0, cfg.upper_trip} - {1'b0, cfg.upper_band_width};
    lower_edge = {1'b0, cfg.lower_trip} + {1'b0, cfg.lower_band_width};
    trip = (value >= cfg.upper_trip) || (value <= cfg.lower_trip);
    hold = upper_edge[VAL_W] || ({1'b0, value} > upper_edge) || ({1'b0, value} < lower_edge);
  end

  always_comb begin
    next_st        = st;
    next_secs      = secs;
    next_latched   = latched;
    next_energized = 1'b0;
    if (cfg.mode != RRA_MODE_RANGE) begin
      next_st   = ST_IDLE;
      next_secs = '0;
      next_latched = 1'b0;
    end else begin
      case (st)
        ST_IDLE: begin
          if (trip) begin
            next_st   = ST_ARMING;
            next_secs = '0;
          end
        end
        ST_ARMING: begin
          if (!trip) begin
            next_st = ST_IDLE;
          end else if (secs >= cfg.assert_delay) begin
            next_st = ST_ON;
            next_latched = cfg.hold_until_cleared;
          end else if (sec_tick) begin
            next_secs = secs + 8'h1;
          end
        end
        ST_ON: begin
          if (!hold && !latched) begin
            next_st   = ST_RELEASING;
            next_secs = '0;
          end
        end
        ST_RELEASING: begin
          if (hold) begin
            next_st = ST_ON;
          end else if (secs >= cfg.release_delay) begin
            next_st = ST_IDLE;
          end else if (sec_tick) begin
            next_secs = secs + 8'h1;
          end
        end
        default: next_st = ST_IDLE;
      endcase
      if (clear && latched) begin
        next_latched = 1'b0;
      end
    end
    next_energized = (cfg.mode == RRA_MODE_MANUAL) ? cfg.forced_on
                   : (next_st == ST_ON) || (next_st == ST_RELEASING);
    next_indicator = next_energized && ((cfg.mode == RRA_MODE_MANUAL) || trip || latched);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st        <= ST_IDLE;
      secs      <= '0;
      latched   <= 1'b0;
      energized <= 1'b0;
      indicator <= 1'b0;
    end else begin
      st        <= next_st;
      secs      <= next_secs;
      latched   <= next_latched;
      energized <= next_energized;
      indicator <= next_indicator;
    end
  end

endmodule // rra_relay

// File: rtl/rra_top.sv
// Top level: two range alarm relays and six remote clear channels
//==========================================================
// How it works
// - Alarm when value reaches upper or lower trip
// - Upper band below trip keeps relay energized
// - Lower band above trip keeps relay energized
// - Wait assert delay seconds before energizing
// - Hold energized release delay after band exit
// - Latch holds relay until keypad or remote clear
// - Manual forced-on energizes relay until deasserted
// - Six remote channels, inputs only
// - Eight selections per channel; disabled does nothing
// - Relay-clear selections clear relay one, two, both
// - Total selections zero total, maybe clear relay
// - Global selection clears both latches and total
// - Any channel combination; each performs its function
// - Confirm keypress steps selection, wraps after last
// - Energize when value outside normal region
// - Indicator when condition met and relay energized
`timescale 1ns/1ns
module rra_top
  import rra_pkg::*;
#(
  parameter int unsigned SEC_DIV = SEC_CYCLES
) (
  input  wire logic                CLK,
  input  wire logic                RST_B,
  input  wire logic [VAL_W-1:0]    SOURCE_VALUE,
  input  rra_relay_cfg_t           RELAY1_CFG,
  input  rra_relay_cfg_t           RELAY2_CFG,
  input  wire logic                KEY_CLEAR_R1,
  input  wire logic                KEY_CLEAR_R2,
  input  wire logic [NUM_CHAN-1:0] REMOTE_IN,
  input  wire logic [2:0]          SEL_CHAN,
  input  wire logic                CONFIRM_KEY,
  output logic                     RELAY1_ENERGIZED,
  output logic                     RELAY2_ENERGIZED,
  output logic                     FIRST_RELAY_INDICATOR,
  output logic                     SECOND_RELAY_INDICATOR,
  output logic                     TOTAL_RESET,
  output logic [NUM_CHAN*FUNC_W-1:0] CHAN_FUNC
);

  //==========================================================
  // Seconds tick
  logic sec_tick;

  rra_sec_tick #(.DIV(SEC_DIV)) u_tick (
    .clk   (CLK),
    .rst_b (RST_B),
    .tick  (sec_tick)
  );

  //==========================================================
  // Remote inputs: two-stage sync then edge detect; never driven
  logic [NUM_CHAN-1:0] sync1;
  logic [NUM_CHAN-1:0] sync2;
  logic [NUM_CHAN-1:0] sync_prev;
  logic [NUM_CHAN-1:0] rise;

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      sync1     <= '0;
      sync2     <= '0;
      sync_prev <= '0;
    end else begin
      sync1     <= REMOTE_IN;
      sync2     <= sync1;
      sync_prev <= sync2;
    end
  end

  always_comb begin
    rise = sync2 & ~sync_prev;
  end

  //==========================================================
  // Channel function selections
  rra_func_t   func      [NUM_CHAN];
  rra_func_t   next_func [NUM_CHAN];
  rra_action_t act       [NUM_CHAN];

  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_chan
      always_comb begin
        next_func[g] = func[g];
        if (CONFIRM_KEY && (SEL_CHAN == 3'(g))) begin
          next_func[g] = rra_func_t'(3'(func[g] + 3'h1));
        end
        act[g] = rise[g] ? rra_decode(func[g]) : '0;
      end

      always_ff @(posedge CLK) begin
        if (!RST_B) begin
          func[g] <= rra_func_t'(FUNC_RESET);
        end else begin
          func[g] <= next_func[g];
        end
      end
    end
  endgenerate

  //==========================================================
  // Combine channel actions
  logic clr1;
  logic clr2;
  logic clr_tot;

  always_comb begin
    clr1    = KEY_CLEAR_R1;
    clr2    = KEY_CLEAR_R2;
    clr_tot = 1'b0;
    for (int i = 0; i < NUM_CHAN; i++) begin
      clr1    = clr1 | act[i].clr_r1;
      clr2    = clr2 | act[i].clr_r2;
      clr_tot = clr_tot | act[i].clr_total;
    end
  end

  //==========================================================
  // Relays
  logic en1;
  logic en2;
  logic ind1;
  logic ind2;

  rra_relay u_r1 (
    .clk       (CLK),
    .rst_b     (RST_B),
    .sec_tick  (sec_tick),
    .value     (SOURCE_VALUE),
    .cfg       (RELAY1_CFG),
    .clear     (clr1),
    .energized (en1),
    .indicator (ind1)
  );

  rra_relay u_r2 (
    .clk       (CLK),
    .rst_b     (RST_B),
    .sec_tick  (sec_tick),
    .value     (SOURCE_VALUE),
    .cfg       (RELAY2_CFG),
    .clear     (clr2),
    .energized (en2),
    .indicator (ind2)
  );

  //==========================================================
  // Output registers (every output on a flop; relay, indicator and total outputs lag one cycle, CHAN_FUNC loads next_func with no lag)
  logic [NUM_CHAN*FUNC_W-1:0] next_chan_func;

  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      next_chan_func[i*FUNC_W +: FUNC_W] = next_func[i];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      RELAY1_ENERGIZED       <= 1'b0;
      RELAY2_ENERGIZED       <= 1'b0;
      FIRST_RELAY_INDICATOR  <= 1'b0;
      SECOND_RELAY_INDICATOR <= 1'b0;
      TOTAL_RESET            <= 1'b0;
      CHAN_FUNC              <= '0;
    end else begin
      RELAY1_ENERGIZED       <= en1;
      RELAY2_ENERGIZED       <= en2;
      FIRST_RELAY_INDICATOR  <= ind1;
      SECOND_RELAY_INDICATOR <= ind2;
      TOTAL_RESET            <= clr_tot;
      CHAN_FUNC              <= next_chan_func;
    end
  end

endmodule // rra_top

// File: sim/rra_top_asserts.sv
// Checker: port-level properties of the relay range alarm top
`timescale 1ns/1ns
module rra_top_asserts
  import rra_pkg::*;
(
  input wire logic                       CLK,
  input wire logic                       RST_B,
  input rra_relay_cfg_t                  RELAY1_CFG,
  input rra_relay_cfg_t                  RELAY2_CFG,
  input wire logic [NUM_CHAN-1:0]        REMOTE_IN,
  input wire logic [2:0]                 SEL_CHAN,
  input wire logic                       CONFIRM_KEY,
  input wire logic                       RELAY1_ENERGIZED,
  input wire logic                       RELAY2_ENERGIZED,
  input wire logic                       FIRST_RELAY_INDICATOR,
  input wire logic                       TOTAL_RESET,
  input wire logic [NUM_CHAN*FUNC_W-1:0] CHAN_FUNC
);
  //==========================================================
  // Properties
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);

  property p_tot_once; TOTAL_RESET |=> !TOTAL_RESET; endproperty
  a_tot_once: assert property (p_tot_once) else $error("total reset wider than one cycle");
  property p_tot_cause; TOTAL_RESET |-> ($past(REMOTE_IN, 3) | $past(REMOTE_IN, 4) | $past(REMOTE_IN, 5)) != '0;
  endproperty
  a_tot_cause: assert property (p_tot_cause) else $error("total reset without remote input");
  property p_disabled; (CHAN_FUNC == '0) [*5] |-> !TOTAL_RESET; endproperty
  a_disabled: assert property (p_disabled) else $error("disabled channels reset total");
  property p_man_on;
    (RELAY1_CFG.mode == RRA_MODE_MANUAL && RELAY1_CFG.forced_on) [*4] |-> RELAY1_ENERGIZED;
  endproperty
  a_man_on: assert property (p_man_on) else $error("forced relay not energized");
  property p_man_off;
    (RELAY2_CFG.mode == RRA_MODE_MANUAL && !RELAY2_CFG.forced_on) [*4] |-> !RELAY2_ENERGIZED;
  endproperty
  a_man_off: assert property (p_man_off) else $error("released manual relay still on");
  property p_ind; FIRST_RELAY_INDICATOR |-> RELAY1_ENERGIZED; endproperty
  a_ind: assert property (p_ind) else $error("indicator without energized relay");
  property p_step;
    CONFIRM_KEY && SEL_CHAN == 3'h3 |=> CHAN_FUNC[11:9] == $past(CHAN_FUNC[11:9]) + 3'h1;
  endproperty
  a_step: assert property (p_step) else $error("confirm did not step selection");
  // Reset itself clears the selections, so a cycle in reset is no antecedent
  property p_keep; RST_B && !CONFIRM_KEY |=> $stable(CHAN_FUNC); endproperty
  a_keep: assert property (p_keep) else $error("selection moved without confirm");
  // Reset itself is the cause here, so the default disable must not apply
  property p_rst;
    disable iff (1'b0) !RST_B |=> !RELAY1_ENERGIZED && !RELAY2_ENERGIZED && CHAN_FUNC == '0 && !TOTAL_RESET;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule // rra_top_asserts

// File: sim/rra_contacts.sv
// Remote contact bank: each request closes one contact for a fixed time
`timescale 1ns/1ns
module rra_contacts
  import rra_pkg::*;
#(
  parameter int unsigned HOLD = 10
) (
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic [NUM_CHAN-1:0] req,
  output logic      [NUM_CHAN-1:0] contact
);
  //==========================================================
  // Contacts
  logic [7:0] cnt [NUM_CHAN];
  // Held well past one cycle, so a level input must still act only once
  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (!rst_b) cnt[i] <= 8'h0;
      else if (req[i]) cnt[i] <= 8'(HOLD);
      else if (cnt[i] != 8'h0) cnt[i] <= cnt[i] - 8'h1;
    end
  end
  // An open contact reads low through its pull-down
  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) contact[i] = cnt[i] != 8'h0;
  end
endmodule // rra_contacts

// File: sim/tb_top.sv
// Testbench: directed scenarios for the relay range alarm top
`timescale 1ns/1ns
module tb_top;
  import rra_pkg::*;
  //==========================================================
  // Signals
  localparam int unsigned SD = 20;
  logic                       CLK = 1'b0;
  logic                       RST_B = 1'b0;
  logic [VAL_W-1:0]           SOURCE_VALUE = '0;
  rra_relay_cfg_t             RELAY1_CFG = '0;
  rra_relay_cfg_t             RELAY2_CFG = '0;
  logic                       KEY_CLEAR_R1 = 1'b0;
  logic                       KEY_CLEAR_R2 = 1'b0;
  logic [NUM_CHAN-1:0]        REMOTE_IN;
  logic [NUM_CHAN-1:0]        req = '0;
  logic [2:0]                 SEL_CHAN = '0;
  logic                       CONFIRM_KEY = 1'b0;
  logic                       RELAY1_ENERGIZED;
  logic                       RELAY2_ENERGIZED;
  logic                       FIRST_RELAY_INDICATOR;
  logic                       SECOND_RELAY_INDICATOR;
  logic                       TOTAL_RESET;
  logic [NUM_CHAN*FUNC_W-1:0] CHAN_FUNC;
  logic [2:0]                 fexp [NUM_CHAN] = '{default: 3'h0};
  int                         err_count = 0;
  int                         n_compared = 0;
  int                         tot_n = 0;
  int                         cycles = 0;

  rra_top #(.SEC_DIV(SD)) rra_top_i (.*);
  rra_contacts rra_contacts_i (.clk(CLK), .rst_b(RST_B), .req(req), .contact(REMOTE_IN));

  always #25 CLK = ~CLK;
  // Run is about 925 cycles; the ceiling leaves ample slack
  always @(posedge CLK) begin
    cycles++;
    if (TOTAL_RESET === 1'b1) tot_n++;
    if (cycles == 5000) begin
      err_count++;
      summarize();
    end
  end

  //==========================================================
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic press();
    @(posedge CLK) CONFIRM_KEY <= 1'b1;
    @(posedge CLK) CONFIRM_KEY <= 1'b0;
    #1;
  endtask
  task automatic set_func(input int ch, input logic [2:0] code);
    @(posedge CLK) SEL_CHAN <= 3'(ch);
    while (fexp[ch] != code) begin
      press();
      fexp[ch] = fexp[ch] + 3'h1;
    end
    chk("func", 8'(CHAN_FUNC[ch*3 +: 3]), 8'(code));
  endtask
  task automatic summarize();
    if (err_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  //==========================================================
  // Scenarios
  task automatic t_keypad();
    @(posedge CLK) SEL_CHAN <= 3'h3;
    for (int i = 1; i <= 8; i++) begin
      press();
      chk("step", 8'(CHAN_FUNC[11:9]), 8'(i % 8));
    end
  endtask
  task automatic t_range();
    logic [15:0] v [9] = '{16'h01f4, 16'h03e8, 16'h03e8, 16'h03c0, 16'h03ac, 16'h03ac, 16'h0064, 16'h0073, 16'h0082};
    int          w [9] = '{30, 15, 50, 60, 15, 50, 65, 60, 70};
    logic [8:0]  e = 9'b011011100;
    logic [8:0]  ind = 9'b001000100;
    @(posedge CLK) begin
      SOURCE_VALUE <= 16'h01f4;
      RELAY1_CFG <= '{mode: RRA_MODE_RANGE, upper_trip: 16'h03e8, lower_trip: 16'h0064, upper_band_width: 16'h0032,
                      lower_band_width: 16'h0014, assert_delay: 8'h02, release_delay: 8'h02, default: '0};
    end
    for (int i = 0; i < 9; i++) begin
      @(posedge CLK) SOURCE_VALUE <= v[i];
      cyc(w[i]);
      chk("relay1", RELAY1_ENERGIZED, e[i]);
      chk("ind1", FIRST_RELAY_INDICATOR, ind[i]);
    end
  endtask
  task automatic t_manual();
    @(posedge CLK) begin
      RELAY1_CFG <= '{mode: RRA_MODE_MANUAL, forced_on: 1'b1, default: '0};
      RELAY2_CFG <= '{mode: RRA_MODE_MANUAL, forced_on: 1'b1, default: '0};
    end
    cyc(4);
    chk("man_on1", RELAY1_ENERGIZED, 1'b1);
    chk("ind1_man", FIRST_RELAY_INDICATOR, 1'b1);
    chk("man_on", RELAY2_ENERGIZED, 1'b1);
    chk("ind2", SECOND_RELAY_INDICATOR, 1'b1);
    @(posedge CLK) begin
      RELAY1_CFG.forced_on <= 1'b0;
      RELAY2_CFG.forced_on <= 1'b0;
    end
    cyc(4);
    chk("man_off1", RELAY1_ENERGIZED, 1'b0);
    chk("man_off", RELAY2_ENERGIZED, 1'b0);
  endtask
  task automatic activate(input int ch, input logic [2:0] c);
    int t0;
    set_func(ch, c);
    @(posedge CLK) SOURCE_VALUE <= 16'h03e8;
    cyc(6);
    @(posedge CLK) SOURCE_VALUE <= 16'h01f4;
    cyc(6);
    chk("latch1", RELAY1_ENERGIZED, 1'b1);
    chk("latch2", RELAY2_ENERGIZED, 1'b1);
    t0 = tot_n;
    @(posedge CLK) req[ch] <= 1'b1;
    @(posedge CLK) req <= '0;
    cyc(20);
    chk("clr1", RELAY1_ENERGIZED, 8'(!c[0]));
    chk("clr2", RELAY2_ENERGIZED, 8'(!c[1]));
    chk("total", 8'(tot_n - t0), 8'(c[2]));
    @(posedge CLK) {KEY_CLEAR_R1, KEY_CLEAR_R2} <= 2'b11;
    @(posedge CLK) {KEY_CLEAR_R1, KEY_CLEAR_R2} <= 2'b00;
    cyc(4);
    chk("keyclr", 8'({RELAY1_ENERGIZED, RELAY2_ENERGIZED}), 8'h00);
  endtask
  task automatic t_remote();
    rra_relay_cfg_t lc;
    lc = '{mode: RRA_MODE_RANGE, upper_trip: 16'h03e8, lower_trip: 16'h0064, hold_until_cleared: 1'b1, default: '0};
    @(posedge CLK) begin
      RELAY1_CFG <= lc;
      RELAY2_CFG <= lc;
    end
    for (int k = 0; k < 8; k++) activate(k % 6, 3'(k));
    // Second channel sharing the total-only selection
    activate(2, 3'h4);
  endtask
  task automatic t_reset();
    // Latch both relays, then reset in mid-run with the value back in the normal region
    @(posedge CLK) SOURCE_VALUE <= 16'h03e8;
    cyc(6);
    chk("pre_rst", 8'({RELAY1_ENERGIZED, RELAY2_ENERGIZED}), 8'h03);
    @(posedge CLK) begin
      SOURCE_VALUE <= 16'h01f4;
      RST_B        <= 1'b0;
    end
    @(posedge CLK) RST_B <= 1'b1;
    cyc(2);
    chk("rst_mid", 8'({RELAY1_ENERGIZED, RELAY2_ENERGIZED, TOTAL_RESET}), 8'h00);
    chk("rst_mid_func", 8'(CHAN_FUNC != '0), 8'h00);
    cyc(10);
    chk("rst_latch", 8'({RELAY1_ENERGIZED, RELAY2_ENERGIZED}), 8'h00);
    fexp = '{default: 3'h0};
  endtask

  //==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge CLK);
    RST_B <= 1'b1;
    cyc(1);
    chk("rst_out", 8'({RELAY1_ENERGIZED, RELAY2_ENERGIZED, TOTAL_RESET}), 8'h00);
    chk("rst_func", 8'(CHAN_FUNC != '0), 8'h00);
    t_keypad();
    t_range();
    t_manual();
    t_remote();
    t_reset();
    summarize();
  end
endmodule // tb_top

bind rra_top rra_top_asserts rra_top_asserts_i (.*);
